/* File: hdl/pcg_top.sv */
`timescale 1ns/100ps
`default_nettype none
module pcg_top
    import pcg_pkg::*;
(
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [19:0] sfr_addr, // CPU register address
    input wire logic sfr_wr, // CPU write strobe
    input wire logic sfr_rd, // CPU read strobe
    input wire logic [7:0] sfr_wdata, // CPU write data
    input wire logic sleep_stop, // STOP mode active
    input wire logic sleep_halt_sub, // HALT with subsystem clock
    input wire logic irq_in, // Pending interrupt requests
    input wire logic [5:0] periph_wr, // Per-peripheral register writes
    output logic [7:0] sfr_rdata, // Read data
    output logic [5:0] periph_clk_en, // Peripheral clock enables
    output logic [5:0] periph_rst_n, // Peripheral resets, low holds
    output logic [5:0] periph_wr_ok, // Gated peripheral writes
    output logic rtc_sub_clk_en, // Counter operating clock enable
    output logic [1:0] speed_band, // Decoded frequency band
    output logic flash_boost_en, // Flash step-up booster on
    output logic cpu_stall, // CPU wait
    output logic irq_hold // Interrupts held back
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] per_en;
    logic [7:0] speed;
    logic [7:0] next_per_en;
    logic [7:0] next_speed;
    logic [7:0] next_rdata;
    logic wr_per;
    logic wr_speed;
    assign wr_per = sfr_wr && (sfr_addr == PCG_ADDR_PER_EN);
    assign wr_speed = sfr_wr && (sfr_addr == PCG_ADDR_SPEED);
    always_comb begin
        next_per_en = per_en;
        next_speed = speed;
        if (wr_per) begin
            // Reserved bits kept zero in hardware as well
            next_per_en = sfr_wdata & PCG_PER_EN_MASK;
        end
        if (wr_speed) begin
            next_speed = 8'h00;
            next_speed[PCG_BIT_RTC_ONLY] = sfr_wdata[PCG_BIT_RTC_ONLY];
            if (speed[PCG_BIT_ONE_MHZ]) begin
                // Low-power band locked; fast bit cannot rise
                next_speed[PCG_BIT_ONE_MHZ] = 1'b1;
                next_speed[PCG_BIT_FAST] = 1'b0;
            end else if (sfr_wdata[PCG_BIT_ONE_MHZ]
                         && sfr_wdata[PCG_BIT_FAST]) begin
                // Prohibited code: keep previous band
                next_speed[PCG_BIT_ONE_MHZ] = speed[PCG_BIT_ONE_MHZ];
                next_speed[PCG_BIT_FAST] = speed[PCG_BIT_FAST];
            end else begin
                next_speed[PCG_BIT_ONE_MHZ] = sfr_wdata[PCG_BIT_ONE_MHZ];
                next_speed[PCG_BIT_FAST] = sfr_wdata[PCG_BIT_FAST];
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            per_en <= PCG_PER_EN_RESET;
            speed <= PCG_SPEED_RESET;
        end else begin
            per_en <= next_per_en;
            speed <= next_speed;
        end
    end
    // ************************************************************
    // Read data
    // ************************************************************
    always_comb begin
        next_rdata = 8'h00;
        if (sfr_rd) begin
            case (sfr_addr)
                PCG_ADDR_PER_EN: begin
                    next_rdata = per_en;
                end
                PCG_ADDR_SPEED: begin
                    next_rdata = speed;
                end
                default: begin
                    // Unmapped addresses read as zero
                    next_rdata = 8'h00;
                end
            endcase
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= next_rdata;
        end
    end
    // ************************************************************
    // Fast-select stall
    // ************************************************************
    pcg_state_t state;
    pcg_state_t next_state;
    logic [7:0] stall_cnt;
    logic [7:0] next_stall_cnt;
    logic fast_rise;
    logic next_cpu_stall;
    logic next_irq_hold;
    // Stall on any write that leaves the fast bit stored as one, even if it was already set
    assign fast_rise = wr_speed && next_speed[PCG_BIT_FAST];
    always_comb begin
        next_state = state;
        next_stall_cnt = stall_cnt;
        case (state)
            PCG_RUN: begin
                if (fast_rise) begin
                    next_state = PCG_STALL;
                    next_stall_cnt = PCG_STALL_CYCLES;
                end
            end
            PCG_STALL: begin
                next_stall_cnt = stall_cnt - 8'h01;
                if (stall_cnt == 8'h01) begin
                    next_state = PCG_RUN;
                end
            end
            default: begin
                next_state = PCG_RUN;
                next_stall_cnt = 8'h00;
            end
        endcase
        next_cpu_stall = (next_state == PCG_STALL);
        // Oscillator counters sit outside; nothing here halts them
        next_irq_hold = (next_state == PCG_STALL) && irq_in;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= PCG_RUN;
            stall_cnt <= 8'h00;
            cpu_stall <= 1'b0;
            irq_hold <= 1'b0;
        end else begin
            state <= next_state;
            stall_cnt <= next_stall_cnt;
            cpu_stall <= next_cpu_stall;
            irq_hold <= next_irq_hold;
        end
    end
    // ************************************************************
    // Band decode and clock gates
    // ************************************************************
    logic sub_cut;
    pcg_band_t next_band;
    logic next_boost;
    logic [PCG_NUM_PERIPH-1:0] cut_vec;
    assign sub_cut = next_speed[PCG_BIT_RTC_ONLY]
                     && (sleep_stop || sleep_halt_sub);
    always_comb begin
        next_band = PCG_BAND_LOW;
        case ({next_speed[PCG_BIT_ONE_MHZ], next_speed[PCG_BIT_FAST]})
            2'h0: begin
                next_band = PCG_BAND_LOW;
            end
            2'h1: begin
                next_band = PCG_BAND_HIGH;
            end
            2'h2: begin
                next_band = PCG_BAND_1MHZ;
            end
            default: begin
                // Unreachable: the write logic never stores this code
                next_band = PCG_BAND_BAD;
            end
        endcase
        // Booster is needed only in the fast band
        next_boost = next_speed[PCG_BIT_FAST];
    end
    always_comb begin
        cut_vec = {PCG_NUM_PERIPH{sub_cut}};
        // Counter access clock survives the sleep cut
        cut_vec[PCG_NUM_PERIPH-1] = 1'b0;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            speed_band <= PCG_BAND_LOW;
            flash_boost_en <= 1'b0;
            rtc_sub_clk_en <= 1'b1;
        end else begin
            speed_band <= next_band;
            flash_boost_en <= next_boost;
            // Counter runs on its own clock regardless of gate bit
            rtc_sub_clk_en <= 1'b1;
        end
    end
    localparam int PCG_POS [PCG_NUM_PERIPH] = '{PCG_BIT_TAU, PCG_BIT_SU0,
        PCG_BIT_SU1, PCG_BIT_TWS, PCG_BIT_ADC, PCG_BIT_RTC};
    generate
        for (genvar i = 0; i < PCG_NUM_PERIPH; i++) begin : g_gate
            pcg_periph_gate u_gate (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .enable(next_per_en[PCG_POS[i]]),
                .sub_cut(cut_vec[i]),
                .wr_req(periph_wr[i]),
                .clk_en(periph_clk_en[i]),
                .rst_hold_n(periph_rst_n[i]),
                .wr_ok(periph_wr_ok[i])
            );
        end
    endgenerate
endmodule
`default_nettype wire

/* File: hdl/pcg_pkg.sv */
package pcg_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [19:0] PCG_ADDR_PER_EN = 20'hF00F0;
    localparam logic [19:0] PCG_ADDR_SPEED = 20'hF00F3;
    localparam logic [7:0] PCG_PER_EN_RESET = 8'h00;
    localparam logic [7:0] PCG_SPEED_RESET = 8'h00;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int PCG_BIT_RTC = 7;
    localparam int PCG_BIT_ADC = 5;
    localparam int PCG_BIT_TWS = 4;
    localparam int PCG_BIT_SU1 = 3;
    localparam int PCG_BIT_SU0 = 2;
    localparam int PCG_BIT_TAU = 0;
    localparam logic [7:0] PCG_PER_EN_MASK = 8'hBD;
    localparam int PCG_BIT_RTC_ONLY = 7;
    localparam int PCG_BIT_ONE_MHZ = 1;
    localparam int PCG_BIT_FAST = 0;
    localparam int PCG_NUM_PERIPH = 6;
    // ************************************************************
    // Timing
    // ************************************************************
    // The half-clock stall is rounded up to whole clocks
    localparam logic [7:0] PCG_STALL_CYCLES = 8'h8D;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        PCG_BAND_LOW = 2'b00,
        PCG_BAND_HIGH = 2'b01,
        PCG_BAND_1MHZ = 2'b10,
        PCG_BAND_BAD = 2'b11
    } pcg_band_t;
    typedef enum logic [0:0] {
        PCG_RUN = 1'b0,
        PCG_STALL = 1'b1
    } pcg_state_t;
endpackage

/* File: hdl/pcg_periph_gate.sv */
`timescale 1ns/100ps
`default_nettype none
module pcg_periph_gate (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset
    input wire logic enable, // Peripheral enable bit
    input wire logic sub_cut, // Subsystem clock cut by sleep option
    input wire logic wr_req, // Peripheral register write request
    output logic clk_en, // Clock gate enable
    output logic rst_hold_n, // Peripheral reset, low holds
    output logic wr_ok // Write passed to peripheral
);
    logic next_clk_en;
    logic next_rst_hold_n;
    logic next_wr_ok;
    always_comb begin
        next_clk_en = enable & ~sub_cut;
        next_rst_hold_n = enable;
        next_wr_ok = enable & wr_req;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            clk_en <= 1'b0;
            rst_hold_n <= 1'b0;
            wr_ok <= 1'b0;
        end else begin
            clk_en <= next_clk_en;
            rst_hold_n <= next_rst_hold_n;
            wr_ok <= next_wr_ok;
        end
    end
endmodule
`default_nettype wire

/* File: verif/pcg_top_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module pcg_top_sva
    import pcg_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset
    input wire logic [19:0] sfr_addr, // Address
    input wire logic sfr_wr, // Write
    input wire logic sfr_rd, // Read
    input wire logic [7:0] sfr_wdata, // Wdata
    input wire logic sleep_stop, // Stop
    input wire logic sleep_halt_sub, // Halt
    input wire logic irq_in, // Irq
    input wire logic [5:0] periph_wr, // Pwr
    input wire logic [7:0] sfr_rdata, // Rdata
    input wire logic [5:0] periph_clk_en, // Clk en
    input wire logic [5:0] periph_rst_n, // Resets
    input wire logic [5:0] periph_wr_ok, // Wr ok
    input wire logic rtc_sub_clk_en, // Rtc clk
    input wire logic [1:0] speed_band, // Band
    input wire logic flash_boost_en, // Boost
    input wire logic cpu_stall, // Stall
    input wire logic irq_hold // Held
);
    // ********
    // Stall length, restarted by every fast-select write
    // ********
    logic start;
    logic [8:0] stall_len;
    logic [8:0] next_stall_len;
    assign start = sfr_wr && sfr_addr == PCG_ADDR_SPEED && sfr_wdata[0];
    always_comb begin
        next_stall_len = stall_len;
        if (!rst_n || start) begin
            next_stall_len = 9'h000;
        end else if (cpu_stall) begin
            next_stall_len = stall_len + 9'h001;
        end
    end
    always_ff @(posedge clk_sys) begin
        stall_len <= next_stall_len;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    property p_rtc_free;
        rtc_sub_clk_en;
    endproperty
    a_rtc_free: assert property (p_rtc_free)
        else $error("rtc clock cut");
    property p_clk_rst;
        (periph_clk_en & ~periph_rst_n) == 6'h00;
    endproperty
    a_clk_rst: assert property (p_clk_rst)
        else $error("clock in reset");
    property p_wr_gate;
        periph_wr_ok == ($past(periph_wr) & periph_rst_n);
    endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("write gate");
    property p_awake;
        !sleep_stop && !sleep_halt_sub && !$past(sleep_stop)
            && !$past(sleep_halt_sub) |-> periph_clk_en == periph_rst_n;
    endproperty
    a_awake: assert property (p_awake) else $error("clock missing");
    property p_stall_go;
        start && !sfr_wdata[1] && !speed_band[1]
            |=> cpu_stall && flash_boost_en;
    endproperty
    a_stall_go: assert property (p_stall_go) else $error("no stall");
    property p_stall_len;
        $fell(cpu_stall) && $past(rst_n) |-> stall_len == 9'h08D;
    endproperty
    a_stall_len: assert property (p_stall_len)
        else $error("stall len");
    property p_band_ok;
        speed_band != 2'b11 && flash_boost_en == speed_band[0];
    endproperty
    a_band_ok: assert property (p_band_ok) else $error("bad band");
    property p_sticky;
        speed_band[1] |=> speed_band == 2'b10;
    endproperty
    a_sticky: assert property (p_sticky) else $error("1 MHz lost");
    property p_read;
        sfr_rd && !sfr_wr && sfr_addr == PCG_ADDR_PER_EN |=> sfr_rdata ==
            {$past(periph_rst_n[5]), 1'b0, $past(periph_rst_n[4:1]), 1'b0,
            $past(periph_rst_n[0])};
    endproperty
    a_read: assert property (p_read) else $error("gate read");
    property p_irq;
        !cpu_stall && !$past(cpu_stall) |-> !irq_hold;
    endproperty
    a_irq: assert property (p_irq) else $error("irq held");
endmodule
bind pcg_top pcg_top_sva u_pcg_top_sva (.clk_sys, .rst_n, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sleep_stop, .sleep_halt_sub, .irq_in,
    .periph_wr, .sfr_rdata, .periph_clk_en, .periph_rst_n, .periph_wr_ok,
    .rtc_sub_clk_en, .speed_band, .flash_boost_en, .cpu_stall, .irq_hold);
`default_nettype wire

/* File: verif/pcg_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module pcg_top_bench import pcg_pkg::*;;
    logic clk_sys, rst_n, sfr_wr, sfr_rd, sleep_stop, sleep_halt_sub, irq_in;
    logic rtc_sub_clk_en, flash_boost_en, cpu_stall, irq_hold;
    logic [19:0] sfr_addr;
    logic [7:0] sfr_wdata, sfr_rdata;
    logic [5:0] periph_wr, periph_clk_en, periph_rst_n, periph_wr_ok;
    logic [1:0] speed_band;
    int err_count, samples_checked, n;
    pcg_top u_pcg_top (.clk_sys, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sleep_stop, .sleep_halt_sub, .irq_in, .periph_wr,
        .sfr_rdata, .periph_clk_en, .periph_rst_n, .periph_wr_ok,
        .rtc_sub_clk_en, .speed_band, .flash_boost_en, .cpu_stall, .irq_hold);
    // ********
    // Bus and check tasks
    // ********
    task automatic chk(input string what, input logic [8:0] e,
        input logic [8:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        chk("rdata", e, sfr_rdata);
    endtask
    task automatic edge_wait(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    // Counts the cycles the stall stands, bounded against a hang
    task automatic stall_cycles();
        n = 0;
        while (cpu_stall === 1'b1 && n < 400) begin
            n++;
            if (n == 5) chk("irq_hold", 1, irq_hold);
            edge_wait(1);
        end
        chk("stall", 141, n);
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_reset();
        rd(PCG_ADDR_PER_EN, 8'h00);
        rd(PCG_ADDR_SPEED, 8'h00);
        rd(20'hF00F1, 8'h00);
        chk("rtc_sub", 1, rtc_sub_clk_en);
        $display("t_reset done");
    endtask
    task automatic t_gate();
        wr(PCG_ADDR_PER_EN, 8'hBD);
        periph_wr <= 6'h3F;
        chk("clk_en", 6'h3F, periph_clk_en);
        rd(PCG_ADDR_PER_EN, 8'hBD);
        chk("wr_ok", 6'h3F, periph_wr_ok);
        wr(PCG_ADDR_PER_EN, 8'h80);
        chk("rst_n", 6'h20, periph_rst_n);
        edge_wait(1);
        chk("wr_ok", 6'h20, periph_wr_ok);
        periph_wr <= 6'h00;
        $display("t_gate done");
    endtask
    task automatic t_speed();
        irq_in <= 1'b1;
        wr(PCG_ADDR_SPEED, 8'h01);
        chk("band", 2'b01, speed_band);
        chk("boost", 1, flash_boost_en);
        stall_cycles();
        edge_wait(1);
        chk("irq_hold", 0, irq_hold);
        wr(PCG_ADDR_SPEED, 8'h03);
        chk("band", 2'b01, speed_band);
        stall_cycles();
        wr(PCG_ADDR_SPEED, 8'h00);
        chk("band", 2'b00, speed_band);
        chk("boost", 0, flash_boost_en);
        wr(PCG_ADDR_SPEED, 8'h02);
        chk("band", 2'b10, speed_band);
        wr(PCG_ADDR_SPEED, 8'h81);
        rd(PCG_ADDR_SPEED, 8'h82);
        chk("stall", 0, cpu_stall);
        irq_in <= 1'b0;
        $display("t_speed done");
    endtask
    task automatic t_sleep();
        wr(PCG_ADDR_PER_EN, 8'hBD);
        sleep_stop <= 1'b1;
        edge_wait(2);
        chk("clk_en", 6'h20, periph_clk_en);
        chk("rst_n", 6'h3F, periph_rst_n);
        sleep_stop <= 1'b0;
        sleep_halt_sub <= 1'b1;
        // Counter-only option off: supply goes on in halt
        wr(PCG_ADDR_SPEED, 8'h02);
        edge_wait(1);
        chk("clk_en", 6'h3F, periph_clk_en);
        sleep_halt_sub <= 1'b0;
        wr(PCG_ADDR_PER_EN, 8'h80);
        wr(PCG_ADDR_SPEED, 8'h82);
        sleep_halt_sub <= 1'b1;
        edge_wait(2);
        chk("clk_en", 6'h20, periph_clk_en);
        chk("rst_n", 6'h20, periph_rst_n);
        sleep_halt_sub <= 1'b0;
        rst_n <= 1'b0;
        edge_wait(2);
        rst_n <= 1'b1;
        $display("t_sleep done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_count++;
        test_done();
    end
    initial begin
        {rst_n, sfr_wr, sfr_rd, sleep_stop, sleep_halt_sub, irq_in} = 6'h00;
        sfr_addr = 20'h00000;
        sfr_wdata = 8'h00;
        periph_wr = 6'h00;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_gate();
        t_speed();
        t_sleep();
        t_reset();
        test_done();
    end
endmodule
`default_nettype wire
